/* src/adf_pkg.sv */
// Constants and register layout of the audio feature and interrupt mask bank
package adf_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_MIXER_ENABLE   = 8'h2C;
    localparam logic [7:0] OFS_FEATURE_ENABLE = 8'h2D;
    localparam logic [7:0] OFS_THRESHOLD      = 8'h2E;
    localparam logic [7:0] OFS_CLKPLL_MASK    = 8'h2F;
    localparam logic [7:0] OFS_FAULT_MASK     = 8'h32;
    localparam logic [7:0] OFS_THRVOICE_MASK  = 8'h33;
    localparam logic [7:0] OFS_CLKPLL_LATCH   = 8'h34;

    // ************************************************************
    // Reset values and writable bits
    // ************************************************************
    localparam logic [7:0] RST_MIXER_ENABLE    = 8'h00;
    localparam logic [7:0] RST_FEATURE_ENABLE  = 8'h00;
    localparam logic [7:0] RST_THRESHOLD       = 8'hBF;
    localparam logic [7:0] RST_CLKPLL_MASK     = 8'hFF;
    localparam logic [7:0] RST_FAULT_MASK      = 8'h00;
    localparam logic [7:0] RST_THRVOICE_MASK   = 8'h30;
    localparam logic [7:0] WR_MIXER_ENABLE     = 8'hF0;
    localparam logic [7:0] WR_FEATURE_ENABLE   = 8'hEF;
    localparam logic [7:0] WR_THRESHOLD        = 8'hFF;
    localparam logic [7:0] WR_CLKPLL_MASK      = 8'hC0;
    localparam logic [7:0] WR_FAULT_MASK       = 8'h3E;
    localparam logic [7:0] WR_THRVOICE_MASK    = 8'hF0;
    localparam logic [7:0] RD_ZERO             = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned MIX_PLAY_BIT  = 7;
    localparam int unsigned MIX_SIDE_BIT  = 6;
    localparam int unsigned MIX_REC_BIT   = 5;
    localparam int unsigned MIX_LOOP_BIT  = 4;
    localparam int unsigned FEA_DIST_BIT  = 7;
    localparam int unsigned FEA_SDP_BIT   = 6;
    localparam int unsigned FEA_THERM_BIT = 5;
    localparam int unsigned FEA_TONE1_BIT = 3;
    localparam int unsigned FEA_TONE2_BIT = 2;
    localparam int unsigned FEA_SEL_BIT   = 1;
    localparam int unsigned FEA_LOWS_BIT  = 0;
    localparam int unsigned CLK_ERR_BIT   = 7;
    localparam int unsigned PLL_LOCK_BIT  = 6;

    // ************************************************************
    // Interrupt sources: two latched here, nine latched elsewhere
    // ************************************************************
    localparam int unsigned LATCH_N = 2;
    localparam int unsigned EXT_N   = 9;

endpackage : adf_pkg

/* src/adf_irq_if.sv */
// Interface between flag latch, interrupt combiner and the register bank
`timescale 1ns/1ps
interface adf_irq_if;
    import adf_pkg::*;

    logic [LATCH_N-1:0] latch_flag;
    logic [EXT_N-1:0]   ext_flag;
    logic [LATCH_N-1:0] latch_mask;
    logic [EXT_N-1:0]   ext_mask;
    logic               irq;

    modport latch (output latch_flag);
    modport comb  (input latch_flag, input ext_flag, input latch_mask, input ext_mask,
                   output irq);
    modport bank  (input latch_flag, output ext_flag, output latch_mask,
                   output ext_mask, input irq);
endinterface : adf_irq_if

/* src/adf_flag_latch.sv */
// Sticky event flags that clear when software reads them
`timescale 1ns/1ps
module adf_flag_latch
    import adf_pkg::*;
#(
    parameter int unsigned N = LATCH_N
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // Events and read clear
    input  wire logic [N-1:0] set_evt,
    input  wire logic         rd_clear,
    // Flags out
    adf_irq_if.latch          irq_bus
);

    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    if (N != LATCH_N) begin : g_chk
        $error("adf_flag_latch: N must equal LATCH_N");
    end

    // A new event in the read cycle survives the clear
    always_comb begin
        flag_d = set_evt | (flag_q & ~{N{rd_clear}});
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign irq_bus.latch_flag = flag_q;

endmodule : adf_flag_latch

/* src/adf_irq_combine.sv */
// Masks the latched flags onto one registered interrupt request
`timescale 1ns/1ps
module adf_irq_combine
    import adf_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Flags, masks and request
    adf_irq_if.comb   irq_bus
);

    logic irq_q;
    logic irq_d;

    // Mask bit of one blocks its source
    always_comb begin
        irq_d = |{irq_bus.latch_flag & ~irq_bus.latch_mask,
                  irq_bus.ext_flag & ~irq_bus.ext_mask};
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq_bus.irq = irq_q;

endmodule : adf_irq_combine

/* src/adf_feature_regs.sv */
// Audio processing feature enables, low-supply threshold and interrupt masks
`timescale 1ns/1ps
module adf_feature_regs
    import adf_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,

    // Control port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_rvalid,

    // Events
    input  wire logic              clock_error_evt,
    input  wire logic              pll_lock_evt,
    input  wire logic [EXT_N-1:0]  ext_event_flags,

    // Supply samples
    input  wire logic [7:0]        supply_sample,
    input  wire logic              supply_sample_valid,

    // Mixer enables
    output logic                   playback_serial_mixer_on,
    output logic                   side_chain_mixer_on,
    output logic                   record_mixer_on,
    output logic                   loopback_mixer_on,

    // Feature enables, low-supply threshold and trip
    output logic                   distortion_limiter_on,
    output logic                   supply_drop_protect_on,
    output logic                   thermal_foldback_on,
    output logic                   tone_gen1_on,
    output logic                   tone_gen2_on,
    output logic                   supply_data_select,
    output logic                   low_supply_shutdown_on,
    output logic [7:0]             low_supply_threshold,
    output logic                   low_supply_trip,

    // Interrupt
    output logic                   irq_req
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] mixer_enable_cfg_q;
    logic [7:0] mixer_enable_cfg_d;
    logic [7:0] feature_enable_cfg_q;
    logic [7:0] feature_enable_cfg_d;
    logic [7:0] supply_drop_threshold_q;
    logic [7:0] supply_drop_threshold_d;
    logic [7:0] clock_pll_irq_mask_q;
    logic [7:0] clock_pll_irq_mask_d;
    logic [7:0] fault_headset_irq_mask_q;
    logic [7:0] fault_headset_irq_mask_d;
    logic [7:0] threshold_voice_irq_mask_q;
    logic [7:0] threshold_voice_irq_mask_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;
    logic       trip_q;
    logic       trip_d;
    logic [7:0] latch_rd;
    logic       latch_clear;

    adf_irq_if irq_bus ();

    // ************************************************************
    // Register writes
    // ************************************************************
    // Writes keep only defined bits so reserved bits never store junk
    always_comb begin
        mixer_enable_cfg_d         = mixer_enable_cfg_q;
        feature_enable_cfg_d       = feature_enable_cfg_q;
        supply_drop_threshold_d    = supply_drop_threshold_q;
        clock_pll_irq_mask_d       = clock_pll_irq_mask_q;
        fault_headset_irq_mask_d   = fault_headset_irq_mask_q;
        threshold_voice_irq_mask_d = threshold_voice_irq_mask_q;
        if (reg_wr) begin
            case (reg_addr)
                OFS_MIXER_ENABLE: begin
                    mixer_enable_cfg_d = reg_wdata & WR_MIXER_ENABLE;
                end
                OFS_FEATURE_ENABLE: begin
                    feature_enable_cfg_d = reg_wdata & WR_FEATURE_ENABLE;
                end
                OFS_THRESHOLD: begin
                    supply_drop_threshold_d = reg_wdata & WR_THRESHOLD;
                end
                OFS_CLKPLL_MASK: begin
                    clock_pll_irq_mask_d = (reg_wdata & WR_CLKPLL_MASK)
                                         | (RST_CLKPLL_MASK & ~WR_CLKPLL_MASK);
                end
                OFS_FAULT_MASK: begin
                    fault_headset_irq_mask_d = reg_wdata & WR_FAULT_MASK;
                end
                OFS_THRVOICE_MASK: begin
                    threshold_voice_irq_mask_d = reg_wdata & WR_THRVOICE_MASK;
                end
                default: begin
                    mixer_enable_cfg_d = mixer_enable_cfg_q;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mixer_enable_cfg_q         <= RST_MIXER_ENABLE;
            feature_enable_cfg_q       <= RST_FEATURE_ENABLE;
            supply_drop_threshold_q    <= RST_THRESHOLD;
            clock_pll_irq_mask_q       <= RST_CLKPLL_MASK;
            fault_headset_irq_mask_q   <= RST_FAULT_MASK;
            threshold_voice_irq_mask_q <= RST_THRVOICE_MASK;
        end else begin
            mixer_enable_cfg_q         <= mixer_enable_cfg_d;
            feature_enable_cfg_q       <= feature_enable_cfg_d;
            supply_drop_threshold_q    <= supply_drop_threshold_d;
            clock_pll_irq_mask_q       <= clock_pll_irq_mask_d;
            fault_headset_irq_mask_q   <= fault_headset_irq_mask_d;
            threshold_voice_irq_mask_q <= threshold_voice_irq_mask_d;
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    always_comb begin
        latch_rd = RD_ZERO;
        latch_rd[CLK_ERR_BIT]  = irq_bus.latch_flag[0];
        latch_rd[PLL_LOCK_BIT] = irq_bus.latch_flag[1];
    end

    // Reading the latch register clears its flags
    assign latch_clear = reg_rd && (reg_addr == OFS_CLKPLL_LATCH);

    always_comb begin
        rvalid_d = reg_rd;
        rdata_d  = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                OFS_MIXER_ENABLE:   rdata_d = mixer_enable_cfg_q;
                OFS_FEATURE_ENABLE: rdata_d = feature_enable_cfg_q;
                OFS_THRESHOLD:      rdata_d = supply_drop_threshold_q;
                OFS_CLKPLL_MASK:    rdata_d = clock_pll_irq_mask_q;
                OFS_FAULT_MASK:     rdata_d = fault_headset_irq_mask_q;
                OFS_THRVOICE_MASK:  rdata_d = threshold_voice_irq_mask_q;
                OFS_CLKPLL_LATCH:   rdata_d = latch_rd;
                default:            rdata_d = RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q  <= RD_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ************************************************************
    // Low-supply shutdown
    // ************************************************************
    // Sample and threshold share the same code scale; the selected
    // scaling to volts is applied in the analog front end
    always_comb begin
        trip_d = trip_q;
        if (!feature_enable_cfg_q[FEA_LOWS_BIT]) begin
            trip_d = 1'b0;
        end else if (supply_sample_valid) begin
            trip_d = (supply_sample < supply_drop_threshold_q);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trip_q <= 1'b0;
        end else begin
            trip_q <= trip_d;
        end
    end

    assign low_supply_trip = trip_q;

    // ************************************************************
    // Configuration outputs
    // ************************************************************
    assign playback_serial_mixer_on = mixer_enable_cfg_q[MIX_PLAY_BIT];
    assign side_chain_mixer_on      = mixer_enable_cfg_q[MIX_SIDE_BIT];
    assign record_mixer_on          = mixer_enable_cfg_q[MIX_REC_BIT];
    assign loopback_mixer_on        = mixer_enable_cfg_q[MIX_LOOP_BIT];
    assign distortion_limiter_on    = feature_enable_cfg_q[FEA_DIST_BIT];
    assign supply_drop_protect_on   = feature_enable_cfg_q[FEA_SDP_BIT];
    assign thermal_foldback_on      = feature_enable_cfg_q[FEA_THERM_BIT];
    assign tone_gen1_on             = feature_enable_cfg_q[FEA_TONE1_BIT];
    assign tone_gen2_on             = feature_enable_cfg_q[FEA_TONE2_BIT];
    // Value zero is passed on as stored; software must not choose it
    assign supply_data_select       = feature_enable_cfg_q[FEA_SEL_BIT];
    assign low_supply_shutdown_on   = feature_enable_cfg_q[FEA_LOWS_BIT];
    assign low_supply_threshold     = supply_drop_threshold_q;

    // ************************************************************
    // Interrupt path
    // ************************************************************
    // Source order: short, vground, insert, remove, hook, up, low, vad up, vad down
    assign irq_bus.ext_flag   = ext_event_flags;
    assign irq_bus.latch_mask = {clock_pll_irq_mask_q[PLL_LOCK_BIT],
                                 clock_pll_irq_mask_q[CLK_ERR_BIT]};
    assign irq_bus.ext_mask   = {threshold_voice_irq_mask_q[4],
                                 threshold_voice_irq_mask_q[5],
                                 threshold_voice_irq_mask_q[6],
                                 threshold_voice_irq_mask_q[7],
                                 fault_headset_irq_mask_q[1],
                                 fault_headset_irq_mask_q[2],
                                 fault_headset_irq_mask_q[3],
                                 fault_headset_irq_mask_q[4],
                                 fault_headset_irq_mask_q[5]};

    adf_flag_latch #(
        .N        (LATCH_N)
    ) u_latch (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .set_evt  ({pll_lock_evt, clock_error_evt}),
        .rd_clear (latch_clear),
        .irq_bus  (irq_bus)
    );

    adf_irq_combine u_comb (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .irq_bus  (irq_bus)
    );

    assign irq_req = irq_bus.irq;

endmodule : adf_feature_regs

/* bench/adf_regs_asserts.sv */
// Port-level assertions for the feature register bank
`timescale 1ns/1ps
module adf_regs_asserts
    import adf_pkg::*;
(
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    // Control port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Events and samples
    input wire logic              clock_error_evt,
    input wire logic              pll_lock_evt,
    input wire logic [EXT_N-1:0]  ext_event_flags,
    input wire logic [7:0]        supply_sample,
    input wire logic              supply_sample_valid,
    // Outputs watched
    input wire logic              playback_serial_mixer_on,
    input wire logic              side_chain_mixer_on,
    input wire logic              record_mixer_on,
    input wire logic              loopback_mixer_on,
    input wire logic              low_supply_shutdown_on,
    input wire logic [7:0]        low_supply_threshold,
    input wire logic              low_supply_trip,
    input wire logic              irq_req
);
    logic [3:0] mix;
    logic [1:0] lmask_q, lmask_d;
    logic [8:0] emask_q, emask_d;
    logic       wr_mix, wr_thr, wr_clk;

    assign mix = {playback_serial_mixer_on, side_chain_mixer_on, record_mixer_on,
                  loopback_mixer_on};
    assign wr_mix = reg_wr && reg_addr == OFS_MIXER_ENABLE;
    assign wr_thr = reg_wr && reg_addr == OFS_THRESHOLD;
    assign wr_clk = reg_wr && reg_addr == OFS_CLKPLL_MASK;

    // ************************************************************
    // Shadow masks, since the checker sees ports only
    // ************************************************************
    always_comb begin
        lmask_d = lmask_q;
        emask_d = emask_q;
        if (wr_clk) lmask_d = reg_wdata[7:6];
        if (reg_wr && reg_addr == OFS_FAULT_MASK)
            emask_d[4:0] = {reg_wdata[1], reg_wdata[2], reg_wdata[3], reg_wdata[4], reg_wdata[5]};
        if (reg_wr && reg_addr == OFS_THRVOICE_MASK)
            emask_d[8:5] = {reg_wdata[4], reg_wdata[5], reg_wdata[6], reg_wdata[7]};
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lmask_q <= 2'h3;
            emask_q <= 9'h180;
        end else begin
            lmask_q <= lmask_d;
            emask_q <= emask_d;
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_mixer_write: assert property (wr_mix |=> mix == $past(reg_wdata[7:4]))
        else $error("mixer enables differ from written data");
    chk_mixer_hold: assert property (!wr_mix |=> $stable(mix))
        else $error("mixer enables changed without a write");
    chk_mixer_read: assert property (reg_rd && reg_addr == OFS_MIXER_ENABLE
        |=> reg_rdata == {$past(mix), 4'h0}) else $error("mixer readback wrong");
    chk_thr_write: assert property (wr_thr |=> low_supply_threshold == $past(reg_wdata))
        else $error("threshold differs from written data");
    chk_thr_read: assert property (reg_rd && reg_addr == OFS_THRESHOLD
        |=> reg_rdata == $past(low_supply_threshold)) else $error("threshold readback wrong");
    chk_mask_read: assert property (reg_rd && reg_addr == OFS_CLKPLL_MASK
        |=> reg_rdata == {$past(lmask_q), 6'h3F}) else $error("clock mask readback wrong");
    chk_trip_off: assert property (!low_supply_shutdown_on |=> !low_supply_trip)
        else $error("trip high with shutdown off");
    chk_trip_cmp: assert property (low_supply_shutdown_on && supply_sample_valid
        |=> low_supply_trip == ($past(supply_sample) < $past(low_supply_threshold)))
        else $error("trip does not follow compare");
    chk_ext_irq: assert property (|(ext_event_flags & ~emask_q) |=> irq_req)
        else $error("unmasked flag gave no request");
    chk_latch_irq: assert property (((clock_error_evt && !lmask_q[1])
        || (pll_lock_evt && !lmask_q[0])) && !wr_clk |=> ##1 irq_req)
        else $error("unmasked event gave no request");
endmodule : adf_regs_asserts

bind adf_feature_regs adf_regs_asserts i_adf_regs_asserts (.ref_clk, .sys_rst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .clock_error_evt, .pll_lock_evt,
    .ext_event_flags, .supply_sample, .supply_sample_valid, .playback_serial_mixer_on,
    .side_chain_mixer_on, .record_mixer_on, .loopback_mixer_on, .low_supply_shutdown_on,
    .low_supply_threshold, .low_supply_trip, .irq_req);

/* bench/tb_top.sv */
// Self-checking bench for the feature register bank
`timescale 1ns/1ps
module tb_top;
    import adf_pkg::*;

    logic       ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, supply_sample = 8'h00;
    logic       clock_error_evt = 1'b0, pll_lock_evt = 1'b0, supply_sample_valid = 1'b0;
    logic [8:0] ext_event_flags = 9'h000;
    logic [7:0] reg_rdata, low_supply_threshold, d, v, mixv, feav, thrv;
    logic       reg_rvalid, playback_serial_mixer_on, side_chain_mixer_on, record_mixer_on;
    logic       loopback_mixer_on, distortion_limiter_on, supply_drop_protect_on;
    logic       thermal_foldback_on, tone_gen1_on, tone_gen2_on, supply_data_select;
    logic       low_supply_shutdown_on, low_supply_trip, irq_req;
    int         bad_count = 0, num_checks = 0, cycles = 0, i, j, k;
    integer     seed = 80897;
    // Last two places: read-only latch and an unmapped hole
    logic [7:0] addrs [8] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h33, 8'h34, 8'h30};
    logic [7:0] rstv  [8] = '{8'h00, 8'h00, 8'hBF, 8'hFF, 8'h00, 8'h30, 8'h00, 8'h00};
    logic [7:0] wmsk  [8] = '{8'hF0, 8'hEF, 8'hFF, 8'hC0, 8'h3E, 8'hF0, 8'h00, 8'h00};

    adf_feature_regs i_adf_feature_regs (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid, .clock_error_evt, .pll_lock_evt,
        .ext_event_flags, .supply_sample, .supply_sample_valid, .playback_serial_mixer_on,
        .side_chain_mixer_on, .record_mixer_on, .loopback_mixer_on, .distortion_limiter_on,
        .supply_drop_protect_on, .thermal_foldback_on, .tone_gen1_on, .tone_gen2_on,
        .supply_data_select, .low_supply_shutdown_on, .low_supply_threshold,
        .low_supply_trip, .irq_req);

    always #5 ref_clk = ~ref_clk;

    // Clock mask bits 5..0 read as ones, everything else reads as stored
    function automatic logic [7:0] exp_rd(input int n, input logic [7:0] x);
        return (x & wmsk[n]) | ((n == 3) ? 8'h3F : 8'h00);
    endfunction : exp_rd

    task automatic final_report;
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask : step

    // Strobe dropped for a cycle so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        reg_addr = a;
        reg_wdata = x;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        step();
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        step();
        reg_rd = 1'b0;
        check(reg_rdata, exp);
        check(reg_rvalid, 1'b1);
        step();
        check(reg_rvalid, 1'b0);
    endtask : rdchk

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        check(low_supply_threshold, 8'hBF);
        for (k = 0; k < 8; k++) rdchk(addrs[k], rstv[k]);
        // ************************************************************
        // Write and read back: all ones, all zeros, then random
        // ************************************************************
        for (j = 0; j < 6; j++) begin
            for (k = 0; k < 8; k++) begin
                d = (j == 0) ? 8'hFF : (j == 1) ? 8'h00 : 8'($random(seed));
                v = (k == 7) ? d : (k == 6) ? (d & 8'hC0) : (d & wmsk[k]);
                if (k == 1) v = v | 8'h02;
                wr(addrs[k], v);
                rdchk(addrs[k], exp_rd(k, v));
                if (k == 0) mixv = v;
                if (k == 1) feav = v;
                if (k == 2) thrv = v;
            end
            check({playback_serial_mixer_on, side_chain_mixer_on, record_mixer_on,
                   loopback_mixer_on, 4'h0}, mixv);
            check({distortion_limiter_on, supply_drop_protect_on, thermal_foldback_on, 1'b0,
                   tone_gen1_on, tone_gen2_on, supply_data_select,
                   low_supply_shutdown_on}, feav);
            check(low_supply_threshold, thrv);
        end
        // ************************************************************
        // Latched events, unmasked then masked
        // ************************************************************
        wr(8'h2D, 8'h02);
        wr(8'h32, 8'h00);
        wr(8'h33, 8'h00);
        for (k = 0; k < 3; k++) begin
            wr(8'h2F, (k == 2) ? 8'hC0 : 8'h00);
            clock_error_evt = (k != 1);
            pll_lock_evt = (k != 0);
            step();
            clock_error_evt = 1'b0;
            pll_lock_evt = 1'b0;
            step();
            check(irq_req, (k != 2));
            rdchk(8'h34, (k == 0) ? 8'h80 : (k == 1) ? 8'h40 : 8'hC0);
            check(irq_req, 1'b0);
            rdchk(8'h34, 8'h00);
        end
        // Event landing in the clearing read must survive it
        reg_addr = 8'h34;
        reg_rd = 1'b1;
        pll_lock_evt = 1'b1;
        step();
        reg_rd = 1'b0;
        pll_lock_evt = 1'b0;
        check(reg_rdata, 8'h00);
        step();
        rdchk(8'h34, 8'h40);
        // ************************************************************
        // Outside flags, each one then its mask
        // ************************************************************
        for (i = 0; i < 9; i++) begin
            ext_event_flags = 9'h001 << i;
            step();
            check(irq_req, 1'b1);
            v = 8'h01 << ((i < 5) ? (5 - i) : (12 - i));
            wr((i < 5) ? 8'h32 : 8'h33, v);
            check(irq_req, 1'b0);
            wr((i < 5) ? 8'h32 : 8'h33, 8'h00);
            ext_event_flags = 9'h000;
        end
        // ************************************************************
        // Low-supply trip, boundary codes first
        // ************************************************************
        wr(8'h2E, 8'h80);
        wr(8'h2D, 8'h03);
        for (j = 0; j < 12; j++) begin
            d = (j == 0) ? 8'h80 : (j == 1) ? 8'h7F : (j == 11) ? 8'h00 : 8'($random(seed));
            supply_sample = d;
            supply_sample_valid = 1'b1;
            step();
            supply_sample_valid = 1'b0;
            supply_sample = ~d;
            step();
            check(low_supply_trip, (d < 8'h80));
        end
        wr(8'h2D, 8'h02);
        check(low_supply_trip, 1'b0);
        // Second reset in mid-run
        sys_rst = 1'b1;
        step();
        sys_rst = 1'b0;
        check(low_supply_threshold, 8'hBF);
        rdchk(8'h2F, 8'hFF);
        rdchk(8'h33, 8'h30);
        final_report();
    end
endmodule : tb_top
